// ==== src/nsi_top.v ====
// Summary of operation
// - service lamp on while service button held
// - lamp off: application loaded and installed
// - lamp steady: no application or run error
// - blink 1 s on/off when not installed
// - brief flash every 2.5 s on watchdog resets
// - health lamp red on failed integrity test
// - health lamp green when test passed, normal
// - health lamp orange while node unbound
// - activity lamp pulses per network communication
// - status lamp blinks 1 s while application runs
// - self-installed: address blinks, pause, repeat
// - relay lamp follows relay one state
// - address from switch positions 1-4, default 0010
// - reset button restarts processor
// - service press during install announces identity
// - position one is msb, position four lsb
// - zero address invalid, no address blinks
// - comm loss red within 10 s, clears
//
// The register offsets and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ps
`include "nsi_map.vh"

module nsi_top
#(
    parameter MS_CYC   = `NSI_CLK_HZ / 1000,
    parameter BLINK_MS = `NSI_BLINK_MS,
    parameter WDT_PER  = `NSI_WDT_PER_MS,
    parameter WDT_ON   = `NSI_WDT_ON_MS,
    parameter ACT_MS   = `NSI_ACT_MS,
    parameter HALF_MS  = `NSI_ADDR_HALF_MS,
    parameter PAUSE_MS = `NSI_PAUSE_MS,
    parameter COMM_MS  = `NSI_COMM_MS
)
(
    input  wire        mclk,
    input  wire        rst_n,
    input  wire [4:0]  avs_address,
    input  wire [3:0]  avs_byteenable,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output wire [31:0] avs_readdata,
    output wire        avs_waitrequest,
    input  wire        service_pushbutton,
    input  wire        processor_reset_pushbutton,
    input  wire [7:0]  address_switch_bank,
    input  wire        output_relay_one,
    output wire        service_lamp,
    output wire        network_health_red,
    output wire        network_health_green,
    output wire        network_activity_lamp,
    output wire        status_lamp,
    output wire        relay_one_lamp,
    output wire        processor_restart,
    output wire        identity_announce
);

    // ======================================================
    // state encodings
    localparam [4:0] SV_ON    = 5'h01;  // steady on
    localparam [4:0] SV_OFF   = 5'h02;  // dark
    localparam [4:0] SV_BLINK = 5'h04;  // 1 s on, 1 s off
    localparam [4:0] SV_WDT   = 5'h08;  // short flash
    localparam [4:0] SV_HELD  = 5'h10;  // button held
    localparam [2:0] ST_OFF   = 3'h1;   // status dark
    localparam [2:0] ST_RUN   = 3'h2;   // run blink
    localparam [2:0] ST_ADDR  = 3'h4;   // address burst

    // ======================================================
    // registers
    reg        wait_ff;        // avalon waitrequest
    reg [31:0] rdata_ff;       // avalon read data
    reg [6:0]  ctrl_ff;        // software state bits
    reg [1:0]  net_ff;         // integrity test result
    reg [3:0]  addr_ff;        // node address
    reg        svc_d_ff;       // service button last
    reg        rst_d_ff;       // reset button last
    reg        ann_ff;         // sticky announce flag
    reg        ann_p_ff;       // announce pulse
    reg        restart_ff;     // restart pulse
    reg [31:0] pre_ff;         // free-running prescaler
    reg        tick_ff;        // one pulse per ms
    reg [4:0]  sv_mode_ff;     // service lamp mode
    reg [15:0] sv_cnt_ff;      // service pattern ms
    reg [2:0]  st_mode_ff;     // status lamp mode
    reg [15:0] st_cnt_ff;      // status pattern ms
    reg [3:0]  st_idx_ff;      // blinks given so far
    reg [15:0] act_cnt_ff;     // activity remaining ms
    reg [15:0] comm_cnt_ff;    // ms since last heard
    reg        comm_lost_ff;   // bound partner silent
    reg        act_lamp_ff;    // activity lamp drive
    reg        sv_lamp_ff;
    reg        red_ff;
    reg        green_ff;
    reg        st_lamp_ff;
    reg        relay_ff;

    // bus decode
    wire       req  = avs_read | avs_write;
    wire       done = req & ~wait_ff;
    wire       wr   = done & avs_write & avs_byteenable[0];
    wire       w_ct = wr & (avs_address == `NSI_OFS_CTRL);
    wire       w_nt = wr & (avs_address == `NSI_OFS_NET);
    wire       w_ev = wr & (avs_address == `NSI_OFS_EVENT);
    wire       ev_act   = w_ev & avs_writedata[`NSI_EV_ACT];
    wire       ev_heard = w_ev & avs_writedata[`NSI_EV_HEARD];
    wire       ev_clr   = w_ev & avs_writedata[`NSI_EV_ANN_CLR];

    // named control fields
    wire       app   = ctrl_ff[`NSI_CTRL_APP];
    wire       inst  = ctrl_ff[`NSI_CTRL_INST];
    wire       err   = ctrl_ff[`NSI_CTRL_ERR];
    wire       wdt   = ctrl_ff[`NSI_CTRL_WDT];
    wire       selfi = ctrl_ff[`NSI_CTRL_SELF];
    wire       logi  = ctrl_ff[`NSI_CTRL_LOGI];
    wire       bound = ctrl_ff[`NSI_CTRL_BOUND];
    wire       svc_rise = service_pushbutton & ~svc_d_ff;

    // switch positions one..four, position one as msb
    wire [3:0] nxt_addr = {address_switch_bank[0], address_switch_bank[1],
                           address_switch_bank[2], address_switch_bank[3]};

    // ======================================================
    // avalon slave: one wait state on every access
    wire [31:0] nxt_rdata =
        (avs_address == `NSI_OFS_CTRL)   ? {25'h0, ctrl_ff} :
        (avs_address == `NSI_OFS_NET)    ? {30'h0, net_ff}  :
        (avs_address == `NSI_OFS_STATUS) ?
            {22'h0, processor_reset_pushbutton, relay_ff, addr_ff,
             (addr_ff != 4'h0), ann_ff, comm_lost_ff, service_pushbutton} :
        32'h0;  // event and unmapped read zero

    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wait_ff  <= 1'b1;
            rdata_ff <= 32'h0000_0000;
            ctrl_ff  <= `NSI_CTRL_RST;
            net_ff   <= `NSI_NET_RST;
        end
        else
        begin
            // drop wait one cycle after a request
            wait_ff <= ~(req & wait_ff);
            if (req & wait_ff)
                rdata_ff <= nxt_rdata;
            // writes land at the completing edge
            if (w_ct)
                ctrl_ff <= avs_writedata[6:0];
            if (w_nt)
                net_ff <= avs_writedata[1:0];
        end
    end

    // ======================================================
    // buttons, switches, relay
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            addr_ff    <= `NSI_ADDR_DFLT;
            svc_d_ff   <= 1'b0;
            rst_d_ff   <= 1'b0;
            ann_ff     <= 1'b0;
            ann_p_ff   <= 1'b0;
            restart_ff <= 1'b0;
            relay_ff   <= 1'b0;
        end
        else
        begin
            addr_ff    <= nxt_addr;
            svc_d_ff   <= service_pushbutton;
            rst_d_ff   <= processor_reset_pushbutton;
            restart_ff <= processor_reset_pushbutton & ~rst_d_ff;
            ann_p_ff   <= svc_rise & logi;
            // set beats clear in the same cycle
            if (svc_rise & logi)
                ann_ff <= 1'b1;
            else if (ev_clr)
                ann_ff <= 1'b0;
            relay_ff   <= output_relay_one;
        end
    end

    // ======================================================
    // free-running ms prescaler
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pre_ff  <= 32'h0000_0000;
            tick_ff <= 1'b0;
        end
        else
        begin
            tick_ff <= (pre_ff == MS_CYC - 1);
            if (pre_ff == MS_CYC - 1)
                pre_ff <= 32'h0000_0000;
            else
                pre_ff <= pre_ff + 32'h0000_0001;
        end
    end

    // ======================================================
    // service lamp mode choice, priority order
    reg [4:0] nxt_sv_mode;
    always @*
    begin
        if (service_pushbutton)
            nxt_sv_mode = SV_HELD;
        else if (wdt)
            nxt_sv_mode = SV_WDT;
        else if (!app || err)
            nxt_sv_mode = SV_ON;
        else if (!inst)
            nxt_sv_mode = SV_BLINK;
        else
            nxt_sv_mode = SV_OFF;
    end

    // service pattern counter restarts on mode change
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sv_mode_ff <= SV_OFF;
            sv_cnt_ff  <= 16'h0000;
            sv_lamp_ff <= 1'b0;
        end
        else
        begin
            sv_mode_ff <= nxt_sv_mode;
            if (nxt_sv_mode != sv_mode_ff)
                sv_cnt_ff <= 16'h0000;
            else if (tick_ff)
            begin
                if ((sv_mode_ff == SV_WDT && sv_cnt_ff == WDT_PER - 1) ||
                    (sv_mode_ff == SV_BLINK && sv_cnt_ff == 2 * BLINK_MS - 1))
                    sv_cnt_ff <= 16'h0000;
                else
                    sv_cnt_ff <= sv_cnt_ff + 16'h0001;
            end
            case (sv_mode_ff)
                SV_HELD:  sv_lamp_ff <= 1'b1;
                SV_ON:    sv_lamp_ff <= 1'b1;
                SV_OFF:   sv_lamp_ff <= 1'b0;
                SV_BLINK: sv_lamp_ff <= (sv_cnt_ff < BLINK_MS);
                SV_WDT:   sv_lamp_ff <= (sv_cnt_ff < WDT_ON);
                default:  sv_lamp_ff <= 1'b0;
            endcase
        end
    end

    // ======================================================
    // status lamp: run blink or address burst
    reg [2:0] nxt_st_mode;
    always @*
    begin
        if (selfi && addr_ff != 4'h0)
            nxt_st_mode = ST_ADDR;
        else if (selfi)
            nxt_st_mode = ST_OFF;
        else if (app && !err)
            nxt_st_mode = ST_RUN;
        else
            nxt_st_mode = ST_OFF;
    end

    // end of one blink slot or of the pause
    wire st_wrap = (st_mode_ff == ST_RUN) ? (st_cnt_ff == 2 * BLINK_MS - 1) :
                   (st_idx_ff < addr_ff)  ? (st_cnt_ff == 2 * HALF_MS - 1)  :
                                            (st_cnt_ff == PAUSE_MS - 1);

    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_mode_ff <= ST_OFF;
            st_cnt_ff  <= 16'h0000;
            st_idx_ff  <= 4'h0;
            st_lamp_ff <= 1'b0;
        end
        else
        begin
            st_mode_ff <= nxt_st_mode;
            // restart burst on mode or address change
            if (nxt_st_mode != st_mode_ff || nxt_addr != addr_ff)
            begin
                st_cnt_ff <= 16'h0000;
                st_idx_ff <= 4'h0;
            end
            else if (tick_ff)
            begin
                if (st_wrap)
                begin
                    st_cnt_ff <= 16'h0000;
                    if (st_mode_ff == ST_ADDR)
                        st_idx_ff <= (st_idx_ff >= addr_ff) ? 4'h0 :
                                     st_idx_ff + 4'h1;
                end
                else
                    st_cnt_ff <= st_cnt_ff + 16'h0001;
            end
            case (st_mode_ff)
                ST_RUN:  st_lamp_ff <= (st_cnt_ff < BLINK_MS);
                ST_ADDR: st_lamp_ff <= (st_idx_ff < addr_ff) &&
                                       (st_cnt_ff < HALF_MS);
                ST_OFF:  st_lamp_ff <= 1'b0;
                default: st_lamp_ff <= 1'b0;
            endcase
        end
    end

    // ======================================================
    // activity pulse and bound-partner supervision
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            act_cnt_ff   <= 16'h0000;
            act_lamp_ff  <= 1'b0;
            comm_cnt_ff  <= 16'h0000;
            comm_lost_ff <= 1'b0;
        end
        else
        begin
            // each communication retriggers the pulse
            if (ev_act)
            begin
                act_cnt_ff  <= ACT_MS[15:0];
                act_lamp_ff <= 1'b1;
            end
            else if (tick_ff && act_cnt_ff != 16'h0000)
            begin
                act_cnt_ff  <= act_cnt_ff - 16'h0001;
                act_lamp_ff <= (act_cnt_ff != 16'h0001);
            end
            else
                act_lamp_ff <= (act_cnt_ff != 16'h0000);
            // silence timer only runs while bound
            if (ev_heard || !bound)
            begin
                comm_cnt_ff  <= 16'h0000;
                comm_lost_ff <= 1'b0;
            end
            else if (tick_ff)
            begin
                if (comm_cnt_ff == COMM_MS - 1)
                    comm_lost_ff <= 1'b1;
                else
                    comm_cnt_ff <= comm_cnt_ff + 16'h0001;
            end
        end
    end

    // ======================================================
    // network health lamp, red wins, orange is both
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            red_ff   <= 1'b0;
            green_ff <= 1'b0;
        end
        else if (net_ff[`NSI_NET_FAIL] || comm_lost_ff)
        begin
            red_ff   <= 1'b1;
            green_ff <= 1'b0;
        end
        else if (!bound)
        begin
            red_ff   <= 1'b1;
            green_ff <= 1'b1;
        end
        else
        begin
            red_ff   <= 1'b0;
            green_ff <= net_ff[`NSI_NET_PASS];
        end
    end

    // ======================================================
    // outputs
    assign avs_waitrequest       = wait_ff;
    assign avs_readdata          = rdata_ff;
    assign service_lamp          = sv_lamp_ff;
    assign network_health_red    = red_ff;
    assign network_health_green  = green_ff;
    assign network_activity_lamp = act_lamp_ff;
    assign status_lamp           = st_lamp_ff;
    assign relay_one_lamp        = relay_ff;
    assign processor_restart     = restart_ff;
    assign identity_announce     = ann_p_ff;

endmodule

// ==== include/nsi_map.vh ====
`ifndef NSI_MAP_VH
`define NSI_MAP_VH
// ==========================================================
// register byte offsets
`define NSI_OFS_CTRL        5'h00
`define NSI_OFS_NET         5'h04
`define NSI_OFS_EVENT       5'h08
`define NSI_OFS_STATUS      5'h0C
// ==========================================================
// control register fields
`define NSI_CTRL_APP        0
`define NSI_CTRL_INST       1
`define NSI_CTRL_ERR        2
`define NSI_CTRL_WDT        3
`define NSI_CTRL_SELF       4
`define NSI_CTRL_LOGI       5
`define NSI_CTRL_BOUND      6
`define NSI_CTRL_RST        7'h00
// network register fields
`define NSI_NET_PASS        0
`define NSI_NET_FAIL        1
`define NSI_NET_RST         2'h0
// event register fields (write only)
`define NSI_EV_ACT          0
`define NSI_EV_HEARD        1
`define NSI_EV_ANN_CLR      2
// ==========================================================
// node address default
`define NSI_ADDR_DFLT       4'h2
// ==========================================================
// timing, in ms unless noted
`define NSI_CLK_HZ          100000000
`define NSI_BLINK_MS        1000
`define NSI_WDT_PER_MS      2500
`define NSI_WDT_ON_MS       100
`define NSI_ACT_MS          50
`define NSI_ADDR_HALF_MS    250
`define NSI_PAUSE_MS        1000
`define NSI_COMM_MS         10000
`endif

// ==== testbench/nsi_panel.sv ====
`timescale 1ns/1ps
// ==========================================================
// installer panel: buttons, address switches, relay contact
module nsi_panel
(
    input  wire       mclk,
    input  wire       rst_n,
    input  wire       svc_push,
    input  wire       rst_push,
    input  wire [7:0] sw_set,
    input  wire       relay_set,
    output reg        svc_ff,
    output reg        rstb_ff,
    output reg        relay_ff,
    output reg  [7:0] sw_ff
);
    // contacts settle one clock after the installer acts
    always @(posedge mclk or negedge rst_n)
        if (!rst_n)
            {svc_ff, rstb_ff, relay_ff, sw_ff} <= {3'b000, 8'h04}; // factory 0010
        else
            {svc_ff, rstb_ff, relay_ff, sw_ff} <= {svc_push, rst_push, relay_set, sw_set};
endmodule

// ==== testbench/nsi_top_asserts.sv ====
`timescale 1ns/1ps
// ==========================================================
// bus handshake and lamp timing watcher
module nsi_top_asserts
#(
    parameter MS_CYC = 4,
    parameter ACT_MS = 3
)
(
    input wire        mclk,
    input wire        rst_n,
    input wire [4:0]  avs_address,
    input wire        avs_read,
    input wire        avs_write,
    input wire [31:0] avs_readdata,
    input wire        avs_waitrequest,
    input wire        service_pushbutton,
    input wire        processor_reset_pushbutton,
    input wire        output_relay_one,
    input wire        service_lamp,
    input wire        network_activity_lamp,
    input wire        relay_one_lamp,
    input wire        processor_restart,
    input wire        identity_announce
);
    // longest activity pulse plus lamp lag
    localparam int ACT_MAX = ACT_MS * MS_CYC + 3;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_bus_wait: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest ##1 avs_waitrequest) else $error("bus wait not one cycle");
    a_empty_read: assert property (!avs_waitrequest && $past(avs_read
        && (avs_address == 5'h08 || avs_address > 5'h0c)) |-> avs_readdata == 32'h0000_0000)
        else $error("write-only or unmapped read not zero");
    a_svc_held: assert property (service_pushbutton [*3] |-> service_lamp)
        else $error("service lamp dark while button held");
    a_relay_mirror: assert property ($past(rst_n) |-> relay_one_lamp == $past(output_relay_one))
        else $error("relay lamp does not follow relay");
    a_restart_rise: assert property ($rose(processor_reset_pushbutton) |=> processor_restart)
        else $error("no restart on reset press");
    a_restart_once: assert property (processor_restart |=> !processor_restart)
        else $error("restart pulse too long");
    a_ann_cause: assert property (identity_announce |-> service_pushbutton || $past(service_pushbutton))
        else $error("announce without service press");
    a_ann_once: assert property (identity_announce |=> !identity_announce)
        else $error("announce pulse too long");
    a_act_hold: assert property ($rose(network_activity_lamp) |-> network_activity_lamp [*8])
        else $error("activity pulse too short");
    a_act_ends: assert property ($rose(network_activity_lamp) |-> ##[1:ACT_MAX] !network_activity_lamp)
        else $error("activity pulse too long");
endmodule

bind nsi_top nsi_top_asserts #(.MS_CYC(MS_CYC), .ACT_MS(ACT_MS)) u_chk (
    .mclk(mclk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .service_pushbutton(service_pushbutton),
    .processor_reset_pushbutton(processor_reset_pushbutton),
    .output_relay_one(output_relay_one), .service_lamp(service_lamp),
    .network_activity_lamp(network_activity_lamp), .relay_one_lamp(relay_one_lamp),
    .processor_restart(processor_restart), .identity_announce(identity_announce));

// ==== testbench/nsi_top_tb.sv ====
`timescale 1ns/1ps
`include "nsi_map.vh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_count++; \
    $display("Error at %0t: got %0h want %0h", $time, (a), (b)); end end

module nsi_top_tb;
    // ==========================================================
    // clock, bus master and installer signals
    reg         mclk = 1'b0;
    reg         rst_n = 1'b0;
    reg  [4:0]  adr = 5'h00;
    reg  [3:0]  ben = 4'h0;
    reg         rdq = 1'b0;
    reg         wrq = 1'b0;
    reg  [31:0] wdat = 32'h0000_0000;
    wire [31:0] rdat;
    wire        wait_rq;
    reg         svc = 1'b0, rbt = 1'b0, rly = 1'b0;
    reg  [7:0]  sws = 8'h04;
    wire        svc_w, rbt_w, rly_w, svc_l, red, grn, act_l, sta_l, rly_l, rstart, ann;
    wire [7:0]  sw_w;
    wire [5:0]  lv = {ann, rstart, rly_l, sta_l, act_l, svc_l};  // watched outputs
    integer     err_count = 0, total_checks = 0, o, r;
    reg  [31:0] q;

    always #5 mclk = ~mclk;

    // activity, address blink and pause keep their own lengths in ms
    nsi_top #(.MS_CYC(4), .BLINK_MS(4), .WDT_PER(10), .WDT_ON(2), .COMM_MS(8)) DUT (
        .mclk(mclk), .rst_n(rst_n), .avs_address(adr), .avs_byteenable(ben),
        .avs_read(rdq), .avs_write(wrq), .avs_writedata(wdat), .avs_readdata(rdat),
        .avs_waitrequest(wait_rq), .service_pushbutton(svc_w),
        .processor_reset_pushbutton(rbt_w), .address_switch_bank(sw_w),
        .output_relay_one(rly_w), .service_lamp(svc_l), .network_health_red(red),
        .network_health_green(grn), .network_activity_lamp(act_l), .status_lamp(sta_l),
        .relay_one_lamp(rly_l), .processor_restart(rstart), .identity_announce(ann));

    nsi_panel u_panel (.mclk(mclk), .rst_n(rst_n), .svc_push(svc), .rst_push(rbt),
        .sw_set(sws), .relay_set(rly), .svc_ff(svc_w), .rstb_ff(rbt_w),
        .relay_ff(rly_w), .sw_ff(sw_w));

    // ==========================================================
    // one bus cycle, held until waitrequest is seen low, then settle
    task bus(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
        integer n;
        n = 0;
        @(posedge mclk);
        {adr, wdat, ben, wrq, rdq} <= {a, d, be, w, !w};
        do
        begin
            @(posedge mclk);
            n++;
        end while (wait_rq !== 1'b0 && n < 40);
        q = rdat;
        {wrq, rdq} <= 2'b00;
        if (n >= 40)
            err_count++;
        repeat (3) @(posedge mclk);
    endtask
    task wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hf);
    endtask
    task rd(input logic [4:0] a);
        bus(1'b0, a, 32'h0000_0000, 4'hf);
    endtask
    // count lit cycles and rising edges of one output
    task watch(input integer n, input integer s);
        integer i;
        reg p;
        o = 0;
        r = 0;
        p = lv[s];
        for (i = 0; i < n; i++)
        begin
            @(posedge mclk);
            if (lv[s] === 1'b1) o++;
            if (lv[s] === 1'b1 && p !== 1'b1) r++;
            p = lv[s];
        end
    endtask

    // ==========================================================
    // scenarios
    task t_bus;
        rd(`NSI_OFS_CTRL);  `CHK(q, 32'h0000_0000)
        rd(`NSI_OFS_NET);   `CHK(q, 32'h0000_0000)
        rd(`NSI_OFS_STATUS); `CHK(q[7:3], 5'h05)
        sws <= 8'hf1;  // position one on, upper positions on
        repeat (2) @(posedge mclk);  // panel and address register settle
        rd(`NSI_OFS_STATUS); `CHK(q[7:3], 5'h11)
        sws <= 8'h04;
        bus(1'b1, `NSI_OFS_CTRL, 32'h0000_007f, 4'he);  // byte 0 not enabled
        rd(`NSI_OFS_CTRL);  `CHK(q, 32'h0000_0000)
        wr(5'h10, 32'hffff_ffff);
        rd(5'h10);  `CHK(q, 32'h0000_0000)
        $display("t_bus done");
    endtask
    task t_svc;
        watch(40, 0);  `CHK(o, 40)
        wr(`NSI_OFS_CTRL, 32'h0000_0003);  watch(40, 0);  `CHK(o, 0)
        wr(`NSI_OFS_CTRL, 32'h0000_0001);  watch(64, 0);  `CHK(o, 32)
        `CHK(r, 2)
        wr(`NSI_OFS_CTRL, 32'h0000_0003);  svc <= 1'b1;
        watch(20, 0);  `CHK(o, 17)
        svc <= 1'b0;
        wr(`NSI_OFS_CTRL, 32'h0000_0009);  watch(80, 0);  `CHK(o, 16)
        `CHK(r, 2)
        $display("t_svc done");
    endtask
    task t_health;
        wr(`NSI_OFS_NET, 32'h0000_0002);  `CHK({red, grn}, 2'b10)
        wr(`NSI_OFS_CTRL, 32'h0000_0043);
        wr(`NSI_OFS_EVENT, 32'h0000_0002);
        wr(`NSI_OFS_NET, 32'h0000_0001);  `CHK({red, grn}, 2'b01)
        repeat (44) @(posedge mclk);
        `CHK({red, grn}, 2'b10)
        rd(`NSI_OFS_STATUS);  `CHK(q[1], 1'b1)
        wr(`NSI_OFS_EVENT, 32'h0000_0002);  `CHK({red, grn}, 2'b01)
        wr(`NSI_OFS_CTRL, 32'h0000_0003);  `CHK({red, grn}, 2'b11)
        wr(`NSI_OFS_NET, 32'h0000_0000);
        $display("t_health done");
    endtask
    task t_act;
        `CHK(act_l, 1'b0)
        wr(`NSI_OFS_EVENT, 32'h0000_0001);  `CHK(act_l, 1'b1)
        repeat (200) @(posedge mclk);  // 50 ms of 4-cycle ticks
        `CHK(act_l, 1'b0)
        $display("t_act done");
    endtask
    task t_status;
        wr(`NSI_OFS_CTRL, 32'h0000_0001);  watch(64, 2);  `CHK(o, 32)
        `CHK(r, 2)
        wr(`NSI_OFS_CTRL, 32'h0000_0013);  watch(8000, 2);  `CHK(r, 2)
        `CHK(o, 2000)
        sws <= 8'h00;
        repeat (4) @(posedge mclk);
        watch(60, 2);  `CHK(o, 0)
        rd(`NSI_OFS_STATUS);  `CHK(q[3], 1'b0)
        sws <= 8'h04;
        $display("t_status done");
    endtask
    task t_relay;
        rly <= 1'b1;
        repeat (4) @(posedge mclk);
        `CHK(rly_l, 1'b1)
        rly <= 1'b0;
        repeat (4) @(posedge mclk);
        `CHK(rly_l, 1'b0)
        $display("t_relay done");
    endtask
    task t_pulse;
        rbt <= 1'b1;  watch(8, 4);  `CHK(o, 1)
        rbt <= 1'b0;
        wr(`NSI_OFS_CTRL, 32'h0000_0021);  svc <= 1'b1;
        watch(8, 5);  `CHK(o, 1)
        svc <= 1'b0;
        rd(`NSI_OFS_STATUS);  `CHK(q[2], 1'b1)
        wr(`NSI_OFS_EVENT, 32'h0000_0004);
        rd(`NSI_OFS_STATUS);  `CHK(q[2], 1'b0)
        wr(`NSI_OFS_CTRL, 32'h0000_0001);  svc <= 1'b1;
        watch(8, 5);  `CHK(o, 0)
        svc <= 1'b0;
        $display("t_pulse done");
    endtask

    // ==========================================================
    // verdict and run control
    task close_out;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        t_bus;
        t_svc;
        t_health;
        t_act;
        t_status;
        t_relay;
        t_pulse;
        close_out;
    end
    // hang guard, well past the roughly nine thousand cycles needed
    initial
    begin
        #200000;
        err_count++;
        close_out;
    end
endmodule
